// >>> xfer_size_pkg.sv
// Purpose: Shared constants, register map and helpers for the DMA transaction size block
// Assumes: 32-bit AXI4-Lite register bus, one aligned word per register
// Notes:   Size codes are powers of two in DWORDs
package xfer_size_pkg;

  localparam int          ADDR_W        = 12;
  localparam int          DATA_W        = 32;
  localparam int          CODE_W        = 4;
  localparam int          DW_CNT_W      = 11;

  // Register byte offsets
  localparam logic [11:0] XFER_SIZE_OFS = 12'h000;
  localparam logic [11:0] PORT_CTRL_OFS = 12'h004;
  localparam logic [11:0] XFER_LEN_OFS  = 12'h008;

  // Field positions
  localparam int          RX_SIZE_LSB   = 4;
  localparam int          TX_SIZE_LSB   = 0;
  localparam int          RUN_BIT       = 0;
  localparam int          GLOBAL_RST_BIT = 1;
  localparam int          RX_LEN_LSB    = 16;
  localparam int          TX_LEN_LSB    = 0;

  // Value after reset and largest size code
  localparam logic [3:0]  XFER_CODE_RST = 4'h0;
  localparam logic [3:0]  XFER_CODE_TOP = 4'hA;

  // Default queue depths
  localparam int          RX_DEPTH_DEF  = 2048;
  localparam int          TX_DEPTH_DEF  = 2048;

  // AXI responses
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // Largest receive code for a receive queue depth
  function automatic logic [3:0] rx_max_code(input int depth);
    int lg;
    lg = $clog2(depth);
    if (depth <= 64) begin
      rx_max_code = 4'h4;
    end else begin
      rx_max_code = 4'((lg - 1) & 15);
    end
  endfunction : rx_max_code

  // Largest transmit code for a transmit queue depth
  function automatic logic [3:0] tx_max_code(input int depth);
    int lg;
    lg = $clog2(depth);
    tx_max_code = 4'((lg - 1) & 15);
  endfunction : tx_max_code

  // DWORD count selected by a size code
  function automatic logic [10:0] code_to_dwords(input logic [3:0] code);
    code_to_dwords = 11'h001 << code;
  endfunction : code_to_dwords

endpackage : xfer_size_pkg

// >>> xfer_size_if.sv
// Purpose: Carries one size field's write request and stored code between modules
// Assumes: One clock domain
// Notes:   One instance per size field
interface xfer_size_if;
  logic       wr_en;
  logic [3:0] wr_code;
  logic       run;
  logic       clear;
  logic [3:0] code;

  modport ctrl  (output wr_en, output wr_code, output run, output clear, input code);
  modport field (input wr_en, input wr_code, input run, input clear, output code);
endinterface : xfer_size_if

// >>> xfer_size_field.sv
// Purpose: Holds one transaction size code with run lock and clamping
// Assumes: Requests come from logic on the same clock
// Notes:   Codes above MAX_CODE are stored as MAX_CODE
module xfer_size_field #(
  parameter logic [3:0] MAX_CODE = 4'hA
) (
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   rst,
  // Field access
  xfer_size_if.field  fld
);

  // Elaboration check on the clamp value
  if (MAX_CODE > xfer_size_pkg::XFER_CODE_TOP) begin : g_bad_max
    $error("MAX_CODE beyond largest size code");
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fld.code <= xfer_size_pkg::XFER_CODE_RST;
    end else if (fld.clear) begin
      fld.code <= xfer_size_pkg::XFER_CODE_RST;
    end else if (fld.wr_en && !fld.run) begin
      if (fld.wr_code > MAX_CODE) begin
        fld.code <= MAX_CODE;
      end else begin
        fld.code <= fld.wr_code;
      end
    end
  end

endmodule : xfer_size_field

// >>> port_dma_xfer_size.sv
// Purpose: Port DMA transaction size register with AXI4-Lite access
// Assumes: Single clock CLK_SYS, asynchronous active-high RST, link reset from a pin
// Notes:   Sizes drive the DWORD counts used by the port DMA engine
module port_dma_xfer_size #(
  parameter int RX_QUEUE_DEPTH_PARAM = xfer_size_pkg::RX_DEPTH_DEF,
  parameter int TX_QUEUE_DEPTH_PARAM = xfer_size_pkg::TX_DEPTH_DEF
) (
  // Clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  // Link reset pin
  input  wire logic        PORT_COMRESET,
  // AXI4-Lite write address
  input  wire logic [11:0] S_AXI_AWADDR,
  input  wire logic [2:0]  S_AXI_AWPROT,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  // AXI4-Lite write data
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  // AXI4-Lite write response
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  // AXI4-Lite read address
  input  wire logic [11:0] S_AXI_ARADDR,
  input  wire logic [2:0]  S_AXI_ARPROT,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  // AXI4-Lite read data
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  // DMA engine controls
  output logic             PORT_RUN,
  output logic [10:0]      RX_XFER_DWORDS,
  output logic [10:0]      TX_XFER_DWORDS
);

  localparam logic [3:0] RX_MAX = xfer_size_pkg::rx_max_code(RX_QUEUE_DEPTH_PARAM);
  localparam logic [3:0] TX_MAX = xfer_size_pkg::tx_max_code(TX_QUEUE_DEPTH_PARAM);

  // Elaboration checks on the queue depths
  if (RX_QUEUE_DEPTH_PARAM < 64 || RX_QUEUE_DEPTH_PARAM > 2048 ||
      (RX_QUEUE_DEPTH_PARAM & (RX_QUEUE_DEPTH_PARAM - 1)) != 0) begin : g_bad_rx_depth
    $error("RX_QUEUE_DEPTH_PARAM must be a power of two from 64 to 2048");
  end
  if (TX_QUEUE_DEPTH_PARAM < 32 || TX_QUEUE_DEPTH_PARAM > 2048 ||
      (TX_QUEUE_DEPTH_PARAM & (TX_QUEUE_DEPTH_PARAM - 1)) != 0) begin : g_bad_tx_depth
    $error("TX_QUEUE_DEPTH_PARAM must be a power of two from 32 to 2048");
  end

  xfer_size_if rx_if ();
  xfer_size_if tx_if ();

  logic        comreset_meta;
  logic        comreset_sync;
  logic        global_rst;
  logic        port_run_bit;
  logic        aw_done;
  logic        w_done;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        do_write;
  logic        next_global_rst;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;

  // Link reset pin synchroniser
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      comreset_meta <= 1'b0;
      comreset_sync <= 1'b0;
    end else begin
      comreset_meta <= PORT_COMRESET;
      comreset_sync <= comreset_meta;
    end
  end

  // Write address channel
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      S_AXI_AWREADY <= 1'b1;
      aw_done       <= 1'b0;
      wr_addr       <= 12'h000;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      S_AXI_AWREADY <= 1'b0;
      aw_done       <= 1'b1;
      wr_addr       <= S_AXI_AWADDR;
    end else if (do_write) begin
      aw_done       <= 1'b0;
    end else if (S_AXI_BVALID && S_AXI_BREADY) begin
      S_AXI_AWREADY <= 1'b1;
    end
  end

  // Write data channel
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      S_AXI_WREADY <= 1'b1;
      w_done       <= 1'b0;
      wr_data      <= 32'h0000_0000;
      wr_strb      <= 4'h0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      S_AXI_WREADY <= 1'b0;
      w_done       <= 1'b1;
      wr_data      <= S_AXI_WDATA;
      wr_strb      <= S_AXI_WSTRB;
    end else if (do_write) begin
      w_done       <= 1'b0;
    end else if (S_AXI_BVALID && S_AXI_BREADY) begin
      S_AXI_WREADY <= 1'b1;
    end
  end

  assign do_write = aw_done && w_done && !S_AXI_BVALID;

  // Write response
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= xfer_size_pkg::RESP_OKAY;
    end else if (do_write) begin
      S_AXI_BVALID <= 1'b1;
      if (wr_addr == xfer_size_pkg::XFER_SIZE_OFS ||
          wr_addr == xfer_size_pkg::PORT_CTRL_OFS ||
          wr_addr == xfer_size_pkg::XFER_LEN_OFS) begin
        S_AXI_BRESP <= xfer_size_pkg::RESP_OKAY;
      end else begin
        S_AXI_BRESP <= xfer_size_pkg::RESP_SLVERR;
      end
    end else if (S_AXI_BVALID && S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // Port run bit, global reset pulse
  always_comb begin
    next_global_rst = do_write && wr_strb[0] &&
                      wr_addr == xfer_size_pkg::PORT_CTRL_OFS &&
                      wr_data[xfer_size_pkg::GLOBAL_RST_BIT];
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      port_run_bit <= 1'b0;
      global_rst   <= 1'b0;
    end else begin
      global_rst <= next_global_rst;
      if (global_rst) begin
        port_run_bit <= 1'b0;
      end else if (do_write && wr_strb[0] && wr_addr == xfer_size_pkg::PORT_CTRL_OFS) begin
        port_run_bit <= wr_data[xfer_size_pkg::RUN_BIT];
      end
    end
  end

  // Size field requests
  always_comb begin
    rx_if.wr_en   = do_write && wr_strb[0] && wr_addr == xfer_size_pkg::XFER_SIZE_OFS;
    rx_if.wr_code = wr_data[xfer_size_pkg::RX_SIZE_LSB +: 4];
    rx_if.run     = port_run_bit;
    rx_if.clear   = global_rst || comreset_sync;
    tx_if.wr_en   = rx_if.wr_en;
    tx_if.wr_code = wr_data[xfer_size_pkg::TX_SIZE_LSB +: 4];
    tx_if.run     = port_run_bit;
    tx_if.clear   = global_rst || comreset_sync;
  end

  xfer_size_field #(
    .MAX_CODE (RX_MAX)
  ) u_rx_field (
    .clk (CLK_SYS),
    .rst (RST),
    .fld (rx_if.field)
  );

  xfer_size_field #(
    .MAX_CODE (TX_MAX)
  ) u_tx_field (
    .clk (CLK_SYS),
    .rst (RST),
    .fld (tx_if.field)
  );

  // Engine controls
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      PORT_RUN       <= 1'b0;
      RX_XFER_DWORDS <= 11'h001;
      TX_XFER_DWORDS <= 11'h001;
    end else begin
      PORT_RUN       <= port_run_bit;
      RX_XFER_DWORDS <= xfer_size_pkg::code_to_dwords(rx_if.code);
      TX_XFER_DWORDS <= xfer_size_pkg::code_to_dwords(tx_if.code);
    end
  end

  // Read decode
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rresp = xfer_size_pkg::RESP_OKAY;
    case (S_AXI_ARADDR)
      xfer_size_pkg::XFER_SIZE_OFS: begin
        next_rdata[xfer_size_pkg::RX_SIZE_LSB +: 4] = rx_if.code;
        next_rdata[xfer_size_pkg::TX_SIZE_LSB +: 4] = tx_if.code;
      end
      xfer_size_pkg::PORT_CTRL_OFS: begin
        next_rdata[xfer_size_pkg::RUN_BIT] = port_run_bit;
      end
      xfer_size_pkg::XFER_LEN_OFS: begin
        next_rdata[xfer_size_pkg::RX_LEN_LSB +: 11] = RX_XFER_DWORDS;
        next_rdata[xfer_size_pkg::TX_LEN_LSB +: 11] = TX_XFER_DWORDS;
      end
      default: begin
        next_rresp = xfer_size_pkg::RESP_SLVERR;
      end
    endcase
  end

  // Read channels
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0000_0000;
      S_AXI_RRESP   <= xfer_size_pkg::RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b1;
      S_AXI_RDATA   <= next_rdata;
      S_AXI_RRESP   <= next_rresp;
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID  <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

endmodule : port_dma_xfer_size

// >>> xfer_size_properties.sv
// Purpose: Port checks for the DMA transaction size register block
// Assumes: Attached by bind, one clock domain
// Notes:   Size limits are worked out from the queue depths
module xfer_size_properties #(
  parameter int RX_QUEUE_DEPTH_PARAM = 2048,
  parameter int TX_QUEUE_DEPTH_PARAM = 2048
) (
  // Clock and reset
  input wire logic        CLK_SYS,
  input wire logic        RST,
  input wire logic        PORT_COMRESET,
  // Register bus
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  // DMA controls
  input wire logic        PORT_RUN,
  input wire logic [10:0] RX_XFER_DWORDS,
  input wire logic [10:0] TX_XFER_DWORDS
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RX_LIM = (RX_QUEUE_DEPTH_PARAM <= 64) ? 16 : RX_QUEUE_DEPTH_PARAM / 2;
  localparam int TX_LIM = TX_QUEUE_DEPTH_PARAM / 2;
  logic [4:0] cr_hist;

  // Recent link reset levels, so the lock check skips their clearing
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      cr_hist <= 5'h00;
    end else begin
      cr_hist <= {cr_hist[3:0], PORT_COMRESET};
    end
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  property p_wr_ans; S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##[1:2] S_AXI_BVALID; endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("Write response missing");
  property p_b_hold; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID; endproperty
  a_b_hold: assert property (p_b_hold) else $error("Write response dropped");
  property p_rd_ans; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("Read data missing");
  property p_r_busy; S_AXI_RVALID |-> !S_AXI_ARREADY; endproperty
  a_r_busy: assert property (p_r_busy) else $error("Read address taken while busy");
  property p_rx_pow; $onehot(RX_XFER_DWORDS); endproperty
  a_rx_pow: assert property (p_rx_pow) else $error("Receive count not a power of two");
  property p_tx_pow; $onehot(TX_XFER_DWORDS); endproperty
  a_tx_pow: assert property (p_tx_pow) else $error("Transmit count not a power of two");
  property p_rx_lim; RX_XFER_DWORDS <= 11'(RX_LIM); endproperty
  a_rx_lim: assert property (p_rx_lim) else $error("Receive count above limit");
  property p_tx_lim; TX_XFER_DWORDS <= 11'(TX_LIM); endproperty
  a_tx_lim: assert property (p_tx_lim) else $error("Transmit count above limit");
  property p_lock; PORT_RUN && $past(PORT_RUN) && cr_hist == 5'h00
    |-> $stable(RX_XFER_DWORDS) && $stable(TX_XFER_DWORDS); endproperty
  a_lock: assert property (p_lock) else $error("Size changed while running");
  property p_link_rst; cr_hist == 5'h1f |-> RX_XFER_DWORDS == 11'h001 && TX_XFER_DWORDS == 11'h001; endproperty
  a_link_rst: assert property (p_link_rst) else $error("Link reset left sizes set");

  c_run_wr: cover property (PORT_RUN && S_AXI_BVALID);
  c_link: cover property (cr_hist == 5'h1f);
  c_rx_top: cover property (RX_XFER_DWORDS == 11'(RX_LIM));
endmodule : xfer_size_properties

// >>> dma_bus_model.sv
// Purpose: System bus side that sizes its bursts from the block's counts
// Assumes: Counts are steady while the port runs
// Notes:   Burst sizes are taken when the run output rises
module dma_bus_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Sizes from the block
  input  wire logic        run,
  input  wire logic [10:0] rx_dwords,
  input  wire logic [10:0] tx_dwords,
  // Burst lengths in use
  output logic      [10:0] wr_burst,
  output logic      [10:0] rd_burst
);
  timeunit 1ns;
  timeprecision 1ps;
  logic run_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run_q    <= 1'b0;
      wr_burst <= 11'h000;
      rd_burst <= 11'h000;
    end else begin
      run_q <= run;
      if (run && !run_q) begin
        wr_burst <= rx_dwords;
        rd_burst <= tx_dwords;
      end
    end
  end
endmodule : dma_bus_model

// >>> port_dma_transaction_size_tb.sv
// Purpose: Register level test of the DMA transaction size block
// Assumes: Queue depths 256 receive and 64 transmit
// Notes:   Expected codes are clamped here from the depths
module port_dma_transaction_size_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RXD = 256;
  localparam int TXD = 64;
  localparam int RXM = $clog2(RXD) - 1;
  localparam int TXM = $clog2(TXD) - 1;
  localparam logic [11:0] SZ = xfer_size_pkg::XFER_SIZE_OFS;
  localparam logic [11:0] CT = xfer_size_pkg::PORT_CTRL_OFS;
  logic        clk, rst, crst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, run;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp;
  logic [10:0] rxdw, txdw, wr_burst, rd_burst;
  int          n_errors, check_count, rx, tx;

  port_dma_xfer_size #(.RX_QUEUE_DEPTH_PARAM(RXD), .TX_QUEUE_DEPTH_PARAM(TXD)) i_port_dma_xfer_size (
    .CLK_SYS(clk), .RST(rst), .PORT_COMRESET(crst), .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .PORT_RUN(run), .RX_XFER_DWORDS(rxdw), .TX_XFER_DWORDS(txdw));
  dma_bus_model i_dma_bus_model (.clk(clk), .rst(rst), .run(run), .rx_dwords(rxdw),
    .tx_dwords(txdw), .wr_burst(wr_burst), .rd_burst(rd_burst));

  task automatic chk_data(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("Error %0t got %h exp %h", $time, g, e);
    end
  endtask : chk_data

  task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("Error %0t got %h exp %h", $time, g, e);
    end
  endtask : chk_resp

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    forever begin
      @(posedge clk);
      if (bvalid) break;
      if (awready && awvalid) awvalid <= 1'b0;
      if (wready && wvalid) wvalid <= 1'b0;
    end
    resp = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    forever begin
      @(posedge clk);
      if (rvalid) break;
      if (arready && arvalid) arvalid <= 1'b0;
    end
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic final_report();
    if (n_errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    final_report();
  end

  initial begin
    {crst, awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    rst = 1'b1;
    wstrb = 4'hf;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(SZ);
    chk_data(d, 32'h0000_0000);
    for (int c = 0; c < 16; c++) begin
      wr(SZ, {24'h00_0000, 4'(c), 4'(15 - c)});
      chk_resp(resp, xfer_size_pkg::RESP_OKAY);
      rx = (c > RXM) ? RXM : c;
      tx = (15 - c > TXM) ? TXM : 15 - c;
      rd(SZ);
      chk_data(d, {24'h00_0000, 4'(rx), 4'(tx)});
      chk_data({21'h00_0000, rxdw}, 32'(1 << rx));
      chk_data({21'h00_0000, txdw}, 32'(1 << tx));
    end
    wr(SZ, 32'h0000_0023);
    wr(CT, 32'h0000_0001);
    rd(CT);
    chk_data(d, 32'h0000_0001);
    wr(SZ, 32'h0000_0045);
    rd(SZ);
    chk_data(d, 32'h0000_0023);
    chk_data({21'h00_0000, wr_burst}, 32'h0000_0004);
    chk_data({21'h00_0000, rd_burst}, 32'h0000_0008);
    rd(xfer_size_pkg::XFER_LEN_OFS);
    chk_data(d, 32'h0004_0008);
    // Run and global reset in one write: the reset pulse must still clear run
    wr(CT, 32'h0000_0003);
    rd(CT);
    chk_data(d, 32'h0000_0000);
    rd(SZ);
    chk_data(d, 32'h0000_0000);
    wr(SZ, 32'h0000_0045);
    rd(SZ);
    chk_data(d, 32'h0000_0045);
    crst <= 1'b1;
    repeat (6) @(posedge clk);
    rd(SZ);
    chk_data(d, 32'h0000_0000);
    crst <= 1'b0;
    repeat (4) @(posedge clk);
    // Byte 0 strobe low: the size write must have no effect
    wstrb <= 4'he;
    wr(SZ, 32'h0000_0012);
    wstrb <= 4'hf;
    rd(SZ);
    chk_data(d, 32'h0000_0000);
    wr(12'h00c, 32'h0000_00ff);
    chk_resp(resp, xfer_size_pkg::RESP_SLVERR);
    rd(12'h00c);
    chk_resp(resp, xfer_size_pkg::RESP_SLVERR);
    chk_data(d, 32'h0000_0000);
    final_report();
  end
endmodule : port_dma_transaction_size_tb

bind port_dma_xfer_size xfer_size_properties #(.RX_QUEUE_DEPTH_PARAM(RX_QUEUE_DEPTH_PARAM),
  .TX_QUEUE_DEPTH_PARAM(TX_QUEUE_DEPTH_PARAM)) i_xfer_size_properties (.CLK_SYS(CLK_SYS),
  .RST(RST), .PORT_COMRESET(PORT_COMRESET), .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
  .PORT_RUN(PORT_RUN), .RX_XFER_DWORDS(RX_XFER_DWORDS), .TX_XFER_DWORDS(TX_XFER_DWORDS));
